// File: hw/radio_irq_flags.sv
// status flags, receive timeouts, pin routing and reference clock select of the radio
//
// Summary of operation
// R1: six 2-bit pin route fields, reset zero
// R2: each pin outputs signal chosen by route
// R3: clock select: divided crystal, RC, off
// R4: mode ready resets one, clears on change
// R5: receive ready after receive chain settles
// R6: transmit ready after amplifier ramp-up
// R7: lock flag tracks synthesizer lock
// R8: level flag on threshold, host clears
// R9: timeout flag from either receive timer
// R10: automatic mode flag follows intermediate mode
// R11: sync match flag, host clears in continuous
// R12: full flag exactly at 66 bytes
// R13: nonempty flag while buffer holds bytes
// R14: level flag above programmed buffer threshold
// R15: overrun flag, write one clears buffer
// R16: packet sent flag, cleared leaving transmit
// R17: payload ready after last byte, CRC gated
// R18: crc good flag, cleared when emptied
// R19: threshold byte, reset e4, half-dB
// R20: receive start timeout, value times 16 bits
// R21: post-level timeout, value times 16 bits
// R22: crc fail clears buffer unless kept
// R23: measured level is 8-bit half-dB magnitude
`timescale 1ns/1ps
`default_nettype none

module radio_irq_flags
	import radio_irq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// radio core status, same clock, except rc_osc_clk, which is asynchronous and synchronized here
	input  wire logic [2:0]        radio_mode,
	input  wire logic              continuous_mode,
	input  wire logic              intermediate_mode,
	input  wire logic              xo_running,
	input  wire logic              pll_locked,
	input  wire logic              rssi_started,
	input  wire logic              pa_ramp_done,
	input  wire logic              rx_chain_done,
	input  wire logic              level_sample,
	input  wire logic [7:0]        signal_level_value,
	input  wire logic              sync_detected,
	input  wire logic [6:0]        buffer_count,
	input  wire logic              buffer_overrun,
	input  wire logic              packet_done,
	input  wire logic              payload_done,
	input  wire logic              crc_pass,
	input  wire logic              crc_enable,
	input  wire logic              keep_on_crc_fail,
	input  wire logic              bit_tick,
	input  wire logic              rc_osc_clk,
	// outputs
	output logic      [5:0]        pin_out,
	output logic                   ref_clock_out,
	output logic                   rc_osc_enable,
	output logic                   buffer_clear,
	output logic                   rx_restart
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	logic [1:0]  route_r [6];
	logic [1:0]  route_nxt [6];
	logic [2:0]  clk_sel_r, clk_sel_nxt;
	logic [7:0]  lvl_thr_r, lvl_thr_nxt;
	logic [7:0]  to_start_r, to_start_nxt;
	logic [7:0]  to_post_r, to_post_nxt;
	logic [6:0]  buf_thr_r, buf_thr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic [7:0]  rd_byte;
	logic        hit;
	logic        wr_acc;

	logic [7:0]  fm_r, fm_nxt;   // mode-related flags, bit 7 down to 0
	logic [7:0]  fb_r, fb_nxt;   // buffer-related flags, bit 7 down to 0
	logic [2:0]  mode_prev_r;
	logic        nonempty_prev_r;
	logic        mode_change, in_rx, in_tx, ready_now, emptied, left_rx;
	logic        clr_level, clr_sync, clr_overrun, crc_fail_drop;
	logic        level_set, payload_set;

	logic [11:0] tmr_s_r, tmr_s_nxt, tmr_p_r, tmr_p_nxt;
	logic        tmr_s_on_r, tmr_s_on_nxt, tmr_p_on_r, tmr_p_on_nxt;
	logic        to_fire;

	logic        clr_pulse_r, clr_pulse_nxt, restart_r, restart_nxt;
	logic [4:0]  div_r, div_nxt;
	logic        rc_s1_r, rc_s2_r, rc_s3_r, rc_q_r, rc_q_nxt;
	logic        refclk_r, refclk_nxt, rc_en_r, rc_en_nxt;
	logic [5:0]  pin_r, pin_nxt;

	////////////////////////////////////////////////////////////////////////////
	// apb slave: answer registered one cycle after setup, so one wait-free access

	assign wr_acc = psel & penable & pready_r & pwrite & ~pslverr_r;

	// read mux and address decode, evaluated during the setup cycle
	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		case (paddr)
			ADR_ROUTE_A:  rd_byte = {route_r[0], route_r[1], route_r[2], route_r[3]};
			ADR_ROUTE_B:  rd_byte = {route_r[4], route_r[5], 1'b0, clk_sel_r};
			ADR_FLAGS_M:  rd_byte = fm_r;
			ADR_FLAGS_B:  rd_byte = fb_r;
			ADR_LVL_THR:  rd_byte = lvl_thr_r;
			ADR_TO_START: rd_byte = to_start_r;
			ADR_TO_POST:  rd_byte = to_post_r;
			ADR_BUF_CFG:  rd_byte = {1'b0, buf_thr_r};
			default:      hit     = 1'b0;
		endcase
		pready_nxt  = psel & ~penable;
		pslverr_nxt = psel & ~penable & ~hit;
		prdata_nxt  = (psel & ~penable) ? {24'h000000, rd_byte} : prdata_r;
	end

	// host-writable configuration
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			route_nxt[i] = route_r[i];
		end
		clk_sel_nxt  = clk_sel_r;
		lvl_thr_nxt  = lvl_thr_r;
		to_start_nxt = to_start_r;
		to_post_nxt  = to_post_r;
		buf_thr_nxt  = buf_thr_r;
		if (wr_acc) begin
			case (paddr)
				ADR_ROUTE_A: begin
					route_nxt[0] = pwdata[7:6];   // R1
					route_nxt[1] = pwdata[5:4];
					route_nxt[2] = pwdata[3:2];
					route_nxt[3] = pwdata[1:0];
				end
				ADR_ROUTE_B: begin
					route_nxt[4] = pwdata[7:6];   // R1
					route_nxt[5] = pwdata[5:4];
					clk_sel_nxt  = pwdata[2:0];   // R3
				end
				ADR_LVL_THR:  lvl_thr_nxt  = pwdata[7:0];   // R19
				ADR_TO_START: to_start_nxt = pwdata[7:0];
				ADR_TO_POST:  to_post_nxt  = pwdata[7:0];
				ADR_BUF_CFG:  buf_thr_nxt  = pwdata[6:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 6; i++) begin
				route_r[i] <= RST_ROUTE;   // R1
			end
			clk_sel_r  <= RST_CLK_SEL;   // R3
			lvl_thr_r  <= RST_LVL_THR;   // R19
			to_start_r <= RST_TIMEOUT;
			to_post_r  <= RST_TIMEOUT;
			buf_thr_r  <= RST_BUF_THR;
			prdata_r   <= 32'h00000000;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
		end else begin
			route_r    <= route_nxt;
			clk_sel_r  <= clk_sel_nxt;
			lvl_thr_r  <= lvl_thr_nxt;
			to_start_r <= to_start_nxt;
			to_post_r  <= to_post_nxt;
			buf_thr_r  <= buf_thr_nxt;
			prdata_r   <= prdata_nxt;
			pready_r   <= pready_nxt;
			pslverr_r  <= pslverr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event flags

	// mode decode and event qualifiers
	always_comb begin
		in_rx       = (radio_mode == MODE_RX);
		in_tx       = (radio_mode == MODE_TX);
		mode_change = (radio_mode != mode_prev_r);
		left_rx     = ~in_rx;
		emptied     = nonempty_prev_r & (buffer_count == 7'h00);
		case (radio_mode)
			MODE_SLEEP:   ready_now = 1'b1;
			MODE_STANDBY: ready_now = xo_running;
			MODE_SYNTH:   ready_now = pll_locked;
			MODE_RX:      ready_now = rssi_started;
			MODE_TX:      ready_now = pa_ramp_done;
			default:      ready_now = 1'b0;
		endcase
		clr_level   = wr_acc & (paddr == ADR_FLAGS_M) & pwdata[BIT_LEVEL];
		clr_sync    = wr_acc & (paddr == ADR_FLAGS_M) & pwdata[BIT_SYNC] & continuous_mode;
		clr_overrun = wr_acc & (paddr == ADR_FLAGS_B) & pwdata[BIT_OVERRUN];
		// stronger signal means a smaller magnitude, both in half-dB steps
		level_set   = in_rx & level_sample & (signal_level_value < lvl_thr_r);   // R8 R23
		crc_fail_drop = in_rx & payload_done & crc_enable & ~crc_pass & ~keep_on_crc_fail;
		payload_set = in_rx & payload_done & (~crc_enable | crc_pass | keep_on_crc_fail);
	end

	// flag next state; a hardware set always beats a host clear in the same cycle
	always_comb begin
		fm_nxt = fm_r;
		fb_nxt = fb_r;
		if (mode_change) begin
			fm_nxt[7] = 1'b0;   // R4
		end else if (ready_now) begin
			fm_nxt[7] = 1'b1;   // R4
		end
		fm_nxt[6] = in_rx & (fm_r[6] | rx_chain_done);   // R5
		fm_nxt[5] = in_tx & (fm_r[5] | pa_ramp_done);    // R6
		fm_nxt[4] = pll_locked & (radio_mode == MODE_SYNTH || in_rx || in_tx);   // R7
		if (level_set) begin
			fm_nxt[3] = 1'b1;   // R8
		end else if (clr_level || left_rx) begin
			fm_nxt[3] = 1'b0;   // R8
		end
		if (to_fire) begin
			fm_nxt[2] = 1'b1;   // R9
		end else if (left_rx || emptied) begin
			fm_nxt[2] = 1'b0;   // R9
		end
		fm_nxt[1] = intermediate_mode;   // R10
		if (in_rx && sync_detected) begin
			fm_nxt[0] = 1'b1;   // R11
		end else if (left_rx || emptied || clr_sync) begin
			fm_nxt[0] = 1'b0;   // R11
		end
		fb_nxt[7] = (buffer_count == BUF_BYTES);   // R12
		fb_nxt[6] = (buffer_count != 7'h00);       // R13
		fb_nxt[5] = (buffer_count > buf_thr_r);    // R14
		if (buffer_overrun && radio_mode != MODE_SLEEP) begin
			fb_nxt[4] = 1'b1;   // R15
		end else if (clr_overrun) begin
			fb_nxt[4] = 1'b0;   // R15
		end
		if (in_tx && packet_done) begin
			fb_nxt[3] = 1'b1;   // R16
		end else if (!in_tx) begin
			fb_nxt[3] = 1'b0;   // R16
		end
		if (payload_set) begin
			fb_nxt[2] = 1'b1;   // R17
		end else if (emptied) begin
			fb_nxt[2] = 1'b0;   // R17
		end
		if (in_rx && payload_done && crc_enable && crc_pass) begin
			fb_nxt[1] = 1'b1;   // R18
		end else if (emptied) begin
			fb_nxt[1] = 1'b0;   // R18
		end
		fb_nxt[0] = 1'b0;
		clr_pulse_nxt = clr_overrun | crc_fail_drop;   // R15 R22
		restart_nxt   = crc_fail_drop;                 // R22
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fm_r            <= 8'h80;   // R4
			fb_r            <= 8'h00;
			mode_prev_r     <= MODE_SLEEP;
			nonempty_prev_r <= 1'b0;
			clr_pulse_r     <= 1'b0;
			restart_r       <= 1'b0;
		end else begin
			fm_r            <= fm_nxt;
			fb_r            <= fb_nxt;
			mode_prev_r     <= radio_mode;
			nonempty_prev_r <= (buffer_count != 7'h00);
			clr_pulse_r     <= clr_pulse_nxt;
			restart_r       <= restart_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive timeouts, counted in bit periods

	// a zero setting never arms its timer; both disarm once receive is left
	always_comb begin
		tmr_s_nxt    = tmr_s_r;
		tmr_s_on_nxt = tmr_s_on_r;
		tmr_p_nxt    = tmr_p_r;
		tmr_p_on_nxt = tmr_p_on_r;
		to_fire      = 1'b0;
		if (in_rx && mode_change) begin
			tmr_s_nxt    = {to_start_r, 4'h0};   // R20
			tmr_s_on_nxt = (to_start_r != 8'h00);   // R20
		end else if (left_rx || level_set) begin
			tmr_s_on_nxt = 1'b0;   // R20
		end else if (tmr_s_on_r && bit_tick) begin
			tmr_s_nxt = tmr_s_r - 12'h001;
			if (tmr_s_r == 12'h001) begin
				tmr_s_on_nxt = 1'b0;
				to_fire      = 1'b1;   // R20
			end
		end
		if (level_set && !fm_r[3]) begin
			tmr_p_nxt    = {to_post_r, 4'h0};    // R21
			tmr_p_on_nxt = (to_post_r != 8'h00);   // R21
		end else if (left_rx || payload_set) begin
			tmr_p_on_nxt = 1'b0;   // R21
		end else if (tmr_p_on_r && bit_tick) begin
			tmr_p_nxt = tmr_p_r - 12'h001;
			if (tmr_p_r == 12'h001) begin
				tmr_p_on_nxt = 1'b0;
				to_fire      = 1'b1;   // R21
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tmr_s_r    <= 12'h000;
			tmr_s_on_r <= 1'b0;
			tmr_p_r    <= 12'h000;
			tmr_p_on_r <= 1'b0;
		end else begin
			tmr_s_r    <= tmr_s_nxt;
			tmr_s_on_r <= tmr_s_on_nxt;
			tmr_p_r    <= tmr_p_nxt;
			tmr_p_on_r <= tmr_p_on_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reference clock output; clk stands for the crystal, so the fastest
	// registered output is half of it and code 0 and 1 both give that rate

	always_comb begin
		div_nxt  = div_r + 5'h01;
		rc_en_nxt = (clk_sel_nxt == CLK_SEL_RC);   // R3
		rc_q_nxt = (rc_s2_r == rc_s3_r) ? rc_s3_r : rc_q_r;
		case (clk_sel_r)
			3'h0, 3'h1: refclk_nxt = div_r[0];   // R3
			3'h2:       refclk_nxt = div_r[1];
			3'h3:       refclk_nxt = div_r[2];
			3'h4:       refclk_nxt = div_r[3];
			3'h5:       refclk_nxt = div_r[4];
			CLK_SEL_RC: refclk_nxt = rc_q_r;     // R3
			default:    refclk_nxt = 1'b0;       // R3
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r    <= 5'h00;
			rc_s1_r  <= 1'b0;
			rc_s2_r  <= 1'b0;
			rc_s3_r  <= 1'b0;
			rc_q_r   <= 1'b0;
			refclk_r <= 1'b0;
			rc_en_r  <= 1'b0;
		end else begin
			div_r    <= div_nxt;
			rc_s1_r  <= rc_osc_clk;
			rc_s2_r  <= rc_s1_r;
			rc_s3_r  <= rc_s2_r;
			rc_q_r   <= rc_q_nxt;
			refclk_r <= refclk_nxt;
			rc_en_r  <= rc_en_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin routing, one selector per pin

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_pin
			// packet mode shows buffer events on codes 0 to 2, continuous mode the link state; code 3 is mode ready in both
			always_comb begin
				if (continuous_mode) begin
					case (route_r[g])
						2'h0:    pin_nxt[g] = fm_r[0];           // R2
						2'h1:    pin_nxt[g] = fm_r[6] | fm_r[5];
						2'h2:    pin_nxt[g] = fm_r[3];
						default: pin_nxt[g] = fm_r[7];
					endcase
				end else begin
					case (route_r[g])
						2'h0:    pin_nxt[g] = in_tx ? fb_r[3] : fb_r[2];   // R2
						2'h1:    pin_nxt[g] = fb_r[5];
						2'h2:    pin_nxt[g] = fb_r[6];
						default: pin_nxt[g] = fm_r[7];
					endcase
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_r <= 6'h00;
		end else begin
			pin_r <= pin_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flip-flops

	assign prdata        = prdata_r;
	assign pready        = pready_r;
	assign pslverr       = pslverr_r;
	assign pin_out       = pin_r;
	assign ref_clock_out = refclk_r;
	assign rc_osc_enable = rc_en_r;   // R3
	assign buffer_clear  = clr_pulse_r;
	assign rx_restart    = restart_r;

endmodule // radio_irq_flags

`default_nettype wire

// File: shared/radio_irq_pkg.sv
// shared constants, register map and mode encoding of the radio flag block
package radio_irq_pkg;
	localparam int ADDR_W = 8;

	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_ROUTE_A  = 8'h25;
	localparam logic [7:0] IDX_ROUTE_B  = 8'h26;
	localparam logic [7:0] IDX_FLAGS_M  = 8'h27;
	localparam logic [7:0] IDX_FLAGS_B  = 8'h28;
	localparam logic [7:0] IDX_LVL_THR  = 8'h29;
	localparam logic [7:0] IDX_TO_START = 8'h2a;
	localparam logic [7:0] IDX_TO_POST  = 8'h2b;
	localparam logic [7:0] IDX_BUF_CFG  = 8'h3c;

	localparam logic [ADDR_W-1:0] ADR_ROUTE_A  = {IDX_ROUTE_A[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADR_ROUTE_B  = {IDX_ROUTE_B[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADR_FLAGS_M  = {IDX_FLAGS_M[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADR_FLAGS_B  = {IDX_FLAGS_B[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADR_LVL_THR  = {IDX_LVL_THR[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADR_TO_START = {IDX_TO_START[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADR_TO_POST  = {IDX_TO_POST[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADR_BUF_CFG  = {IDX_BUF_CFG[5:0], 2'b00};

	// values after reset
	localparam logic [1:0] RST_ROUTE    = 2'h0;
	localparam logic [2:0] RST_CLK_SEL  = 3'h7;
	localparam logic [7:0] RST_LVL_THR  = 8'he4;
	localparam logic [7:0] RST_TIMEOUT  = 8'h00;
	localparam logic [6:0] RST_BUF_THR  = 7'h0f;

	// clock output select codes
	localparam logic [2:0] CLK_SEL_RC   = 3'h6;
	localparam logic [2:0] CLK_SEL_OFF  = 3'h7;

	// field positions in the write-one-to-clear flag registers
	localparam int BIT_LEVEL   = 3;
	localparam int BIT_SYNC    = 0;
	localparam int BIT_OVERRUN = 4;

	// buffer capacity in bytes and log2 of the timeout scale (bit periods per step)
	localparam logic [6:0] BUF_BYTES    = 7'h42;
	localparam int         TO_STEP_LOG2 = 4;

	typedef enum logic [2:0] {
		MODE_SLEEP   = 3'b000,
		MODE_STANDBY = 3'b001,
		MODE_SYNTH   = 3'b010,
		MODE_TX      = 3'b011,
		MODE_RX      = 3'b100
	} radio_mode_t;
endpackage

// File: verification/radio_host.sv
// host model: apb master that reaches the flag registers
`timescale 1ns/1ps
`default_nettype none
module radio_host
	import radio_irq_pkg::*;
(
	input  wire logic              clk,
	output logic                   psel,
	output logic                   penable,
	output logic                   pwrite,
	output logic      [ADDR_W-1:0] paddr,
	output logic      [31:0]       pwdata,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr
);
	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	// one transfer; no latency assumed, the bench timeout ends a hang
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		// released data shows no stale value
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~pwdata;
	endtask
endmodule // radio_host
`default_nettype wire

// File: verification/radio_irq_flags_props.sv
// port checker of the radio flag block
`timescale 1ns/1ps
`default_nettype none
module radio_irq_flags_chk
	import radio_irq_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [2:0]        radio_mode,
	input wire logic              continuous_mode,
	input wire logic              payload_done,
	input wire logic              crc_pass,
	input wire logic              crc_enable,
	input wire logic              keep_on_crc_fail,
	input wire logic [5:0]        pin_out,
	input wire logic              ref_clock_out,
	input wire logic              rc_osc_enable,
	input wire logic              buffer_clear,
	input wire logic              rx_restart
);
	logic [1:0] p0_r;
	logic [1:0] p0_nxt;
	logic [2:0] sel_r;
	logic [2:0] sel_nxt;
	logic       wr_done;
	logic       crc_drop;

	////////////////////////////////////////////////////////////////////////////////
	// mirror of pin0 route and clock select, taken at the access edge
	assign wr_done = psel && penable && pready && pwrite;
	assign crc_drop = payload_done && crc_enable && !crc_pass && !keep_on_crc_fail;
	always_comb begin
		p0_nxt = p0_r;
		sel_nxt = sel_r;
		if (wr_done && paddr == ADR_ROUTE_A)
			p0_nxt = pwdata[7:6];
		if (wr_done && paddr == ADR_ROUTE_B)
			sel_nxt = pwdata[2:0];
	end
	always_ff @(posedge clk) begin
		p0_r <= rst_n ? p0_nxt : RST_ROUTE;
		sel_r <= rst_n ? sel_nxt : RST_CLK_SEL;
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_rc_en; rc_osc_enable == (sel_r == CLK_SEL_RC); endproperty
	a_rc_en: assert property (p_rc_en) else $error("rc enable wrong");
	// output is registered, so the select must have stood two cycles
	property p_clk_off;
		sel_r == CLK_SEL_OFF && $stable(sel_r) && $past(sel_r, 2) == CLK_SEL_OFF |-> !ref_clock_out;
	endproperty
	a_clk_off: assert property (p_clk_off) else $error("clock out not off");
	property p_clk_div2;
		sel_r == 3'h1 && $stable(sel_r) && $past(sel_r, 2) == 3'h1 |-> $changed(ref_clock_out);
	endproperty
	a_clk_div2: assert property (p_clk_div2) else $error("clock out not halved");
	property p_crc_drop; crc_drop && radio_mode == MODE_RX |=> buffer_clear && rx_restart; endproperty
	a_crc_drop: assert property (p_crc_drop) else $error("crc fail not flushed");
	property p_restart_cause; rx_restart |-> $past(crc_drop); endproperty
	a_restart_cause: assert property (p_restart_cause) else $error("stray restart");
	property p_ovr_clear;
		wr_done && paddr == ADR_FLAGS_B && pwdata[BIT_OVERRUN] |-> ##[1:2] buffer_clear;
	endproperty
	a_ovr_clear: assert property (p_ovr_clear) else $error("overrun clear lost");
	property p_unmapped; psel && !penable && paddr == 8'h00 |=> pready && pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	property p_rdata_width; pready |-> prdata[31:8] == 24'h000000; endproperty
	a_rdata_width: assert property (p_rdata_width) else $error("read data too wide");
	property p_pin_payload;
		payload_done && crc_pass && radio_mode == MODE_RX && !continuous_mode && p0_r == 2'h0
			|-> ##2 pin_out[0];
	endproperty
	a_pin_payload: assert property (p_pin_payload) else $error("pin0 missed payload");

	c_crc_drop: cover property (rx_restart);
	c_ovr: cover property (buffer_clear && !rx_restart);
	c_refused: cover property (pready && pslverr);
endmodule // radio_irq_flags_chk

bind radio_irq_flags radio_irq_flags_chk u_chk (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .radio_mode, .continuous_mode, .payload_done,
	.crc_pass, .crc_enable, .keep_on_crc_fail, .pin_out, .ref_clock_out, .rc_osc_enable,
	.buffer_clear, .rx_restart);
`default_nettype wire

// File: verification/radio_irq_flags_test.sv
// self-checking bench of the radio flag block
`timescale 1ns/1ps
`default_nettype none
module radio_irq_flags_test
	import radio_irq_pkg::*;
	;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic [2:0]        radio_mode = MODE_SLEEP;
	logic              continuous_mode = 0, intermediate_mode = 0, xo_running = 0, pll_locked = 0;
	logic              rssi_started = 0, pa_ramp_done = 0, rx_chain_done = 0, level_sample = 0;
	logic              sync_detected = 0, buffer_overrun = 0, packet_done = 0, payload_done = 0;
	logic              crc_pass = 0, crc_enable = 0, keep_on_crc_fail = 0, bit_tick = 0;
	logic              rc_osc_clk = 0;
	logic [7:0]        signal_level_value = 8'hff;
	logic [6:0]        buffer_count = 7'h00;
	logic [5:0]        pin_out;
	logic              ref_clock_out, rc_osc_enable, buffer_clear, rx_restart;
	int                n_mismatch = 0, checks_done = 0, cycles = 0;
	logic [ADDR_W-1:0] ra [8] = '{ADR_ROUTE_A, ADR_ROUTE_B, ADR_FLAGS_M, ADR_FLAGS_B,
		ADR_LVL_THR, ADR_TO_START, ADR_TO_POST, ADR_BUF_CFG};
	logic [7:0]        rv [8] = '{8'h00, 8'h07, 8'h80, 8'h00, 8'he4, 8'h00, 8'h00, 8'h0f};
	logic [6:0]        corner [6] = '{7'h00, 7'h01, 7'h0f, 7'h10, 7'h41, 7'h42};

	radio_irq_flags DUT (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .radio_mode, .continuous_mode, .intermediate_mode, .xo_running,
		.pll_locked, .rssi_started, .pa_ramp_done, .rx_chain_done, .level_sample,
		.signal_level_value, .sync_detected, .buffer_count, .buffer_overrun, .packet_done,
		.payload_done, .crc_pass, .crc_enable, .keep_on_crc_fail, .bit_tick, .rc_osc_clk,
		.pin_out, .ref_clock_out, .rc_osc_enable, .buffer_clear, .rx_restart);
	radio_host host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

	////////////////////////////////////////////////////////////////////////////////
	// clocks; rc phase offset keeps its edges off the sampling edge
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		#3;
		forever #30 rc_osc_clk = ~rc_osc_clk;
	end
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		logic e;
		host.xfer(1'b0, a, 8'h00, d, e);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [7:0] x;
		logic       e;
		host.xfer(1'b1, a, d, x, e);
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [2:0] fifo_exp(input logic [6:0] n);
		return {n == BUF_BYTES, n != 7'h00, n > RST_BUF_THR};
	endfunction
	function automatic logic pay_exp(input logic [2:0] c);
		return !c[2] || c[1] || c[0];
	endfunction
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] d;
		logic [7:0] x;
		logic       e;
		logic [6:0] cnt;
		void'($urandom(32'h900b427d));
		step(2);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(ra[i], d);
			chk("reset value", d, rv[i]);
		end
		host.xfer(1'b0, 8'h00, 8'h00, d, e);
		chk("unmapped data", d, 8'h00);
		chk("unmapped error", 8'(e), 8'h01);
		x = 8'($urandom);
		wr(ADR_ROUTE_A, x);
		rd(ADR_ROUTE_A, d);
		chk("route a", d, x);
		wr(ADR_ROUTE_B, 8'hff);
		rd(ADR_ROUTE_B, d);
		chk("route b", d, 8'hf7);
		for (int k = 0; k < 8; k++) begin
			wr(ADR_ROUTE_B, 8'(k));
			step(3);
			chk("rc enable", 8'(rc_osc_enable), 8'(k == 6));
		end
		wr(ADR_ROUTE_A, 8'h00);
		// mode change clears ready until the crystal runs
		radio_mode <= MODE_STANDBY;
		step(2);
		rd(ADR_FLAGS_M, d);
		chk("mode ready", 8'(d[7]), 8'h00);
		xo_running <= 1'b1;
		step(1);
		rd(ADR_FLAGS_M, d);
		chk("mode ready", 8'(d[7]), 8'h01);
		radio_mode <= MODE_SYNTH;
		repeat (12) begin
			{pll_locked, intermediate_mode, rssi_started, pa_ramp_done, rx_chain_done} <= 5'($urandom);
			step(2);
			rd(ADR_FLAGS_M, d);
			chk("lock", 8'(d[4]), 8'(pll_locked));
			chk("auto mode", 8'(d[1]), 8'(intermediate_mode));
			chk("rx tx ready", 8'(d[6:5]), 8'h00);
		end
		for (int i = 0; i < 12; i++) begin
			cnt = (i < 6) ? corner[i] : 7'($urandom_range(66));
			buffer_count <= cnt;
			step(1);
			rd(ADR_FLAGS_B, d);
			chk("buffer flags", 8'(d[7:5]), 8'(fifo_exp(cnt)));
		end
		// overrun: set, host clear, then ignored in sleep
		for (int s = 0; s < 2; s++) begin
			radio_mode <= s ? MODE_SLEEP : MODE_STANDBY;
			buffer_overrun <= 1'b1;
			step(1);
			buffer_overrun <= 1'b0;
			rd(ADR_FLAGS_B, d);
			chk("overrun", 8'(d[BIT_OVERRUN]), 8'(s == 0));
			wr(ADR_FLAGS_B, 8'h10);
			rd(ADR_FLAGS_B, d);
			chk("overrun cleared", 8'(d[BIT_OVERRUN]), 8'h00);
		end
		// transmit: packet sent
		radio_mode <= MODE_TX;
		packet_done <= 1'b1;
		step(1);
		packet_done <= 1'b0;
		rd(ADR_FLAGS_B, d);
		chk("packet sent", 8'(d[3]), 8'h01);
		// start timeout: fires on the value*16-th bit period
		wr(ADR_TO_START, 8'h02);
		radio_mode <= MODE_RX;
		step(1);
		for (int t = 1; t <= 2 << TO_STEP_LOG2; t++) begin
			bit_tick <= 1'b1;
			step(1);
			bit_tick <= 1'b0;
			step(1);
			if (t >= 31) begin
				rd(ADR_FLAGS_M, d);
				chk("timeout", 8'(d[2]), 8'(t == 32));
			end
		end
		// equal to threshold is not stronger; later a host clear
		for (int j = 0; j < 3; j++) begin
			signal_level_value <= j ? 8'h10 : RST_LVL_THR;
			level_sample <= 1'b1;
			step(1);
			level_sample <= 1'b0;
			if (j == 1)
				wr(ADR_FLAGS_M, 8'h08);
			rd(ADR_FLAGS_M, d);
			chk("level flag", 8'(d[BIT_LEVEL]), 8'(j == 2));
		end
		for (int c = 1; c >= 0; c--) begin
			continuous_mode <= c[0];
			sync_detected <= 1'b1;
			step(1);
			sync_detected <= 1'b0;
			wr(ADR_FLAGS_M, 8'h01);
			rd(ADR_FLAGS_M, d);
			chk("sync", 8'(d[BIT_SYNC]), 8'(c == 0));
		end
		continuous_mode <= 1'b0;
		radio_mode <= MODE_STANDBY;
		step(1);
		rd(ADR_FLAGS_M, d);
		chk("left receive", d & 8'h4d, 8'h00);
		radio_mode <= MODE_RX;
		// every crc enable, pass and keep combination, then emptied
		for (int i = 0; i < 8; i++) begin
			{crc_enable, crc_pass, keep_on_crc_fail} <= 3'(i);
			buffer_count <= 7'h05;
			payload_done <= 1'b1;
			step(1);
			payload_done <= 1'b0;
			rd(ADR_FLAGS_B, d);
			chk("payload", 8'(d[2]), 8'(pay_exp(3'(i))));
			if (i >= 4)
				chk("crc good", 8'(d[1]), 8'(i[1]));
			buffer_count <= 7'h00;
			step(1);
			rd(ADR_FLAGS_B, d);
			chk("emptied", 8'(d[3:1]), 8'h00);
		end
		summarize();
	end
endmodule // radio_irq_flags_test
`default_nettype wire
